/* File: cidt_pkg.sv */
// Package for the instruction decode and execution timing block.
// Assumes a single core clock; opcode bytes arrive from the fetch logic on that clock.
package cidt_pkg;

    localparam int CYC_W = 21;   // Holds 5 + 22 * 65535
    localparam int BASE_W = 6;
    localparam int PER_W = 5;

    // Opcode bytes
    localparam logic [7:0] OP_AND_RM = 8'h20;    // 20..23, low two bits d and w
    localparam logic [7:0] OP_AND_ACC = 8'h24;   // 24..25
    localparam logic [7:0] OP_OR_RM = 8'h08;
    localparam logic [7:0] OP_OR_ACC = 8'h0c;
    localparam logic [7:0] OP_XOR_RM = 8'h30;
    localparam logic [7:0] OP_XOR_ACC = 8'h34;
    localparam logic [7:0] OP_TEST_RM = 8'h84;   // 84..85
    localparam logic [7:0] OP_TEST_ACC = 8'ha8;  // a8..a9
    localparam logic [7:0] OP_UNARY = 8'hf6;     // f6..f7
    localparam logic [7:0] OP_ASCII_MUL_ADJ = 8'hd4;
    localparam logic [7:0] OP_ASCII_DIV_ADJ = 8'hd5;
    localparam logic [7:0] OP_BYTE_EXTEND = 8'h98;
    localparam logic [7:0] OP_WORD_EXTEND = 8'h99;
    localparam logic [7:0] OP_COPY = 8'ha4;      // a4..a5
    localparam logic [7:0] OP_CMP = 8'ha6;
    localparam logic [7:0] OP_STORE = 8'haa;
    localparam logic [7:0] OP_LOAD = 8'hac;
    localparam logic [7:0] OP_SCAN = 8'hae;
    localparam logic [7:0] OP_CALL_NEAR = 8'he8;
    localparam logic [7:0] OP_CALL_FAR = 8'h9a;
    localparam logic [7:0] OP_GROUP = 8'hff;
    localparam logic [7:0] OP_NEAR_EXIT = 8'hc3;
    localparam logic [7:0] OP_NEAR_EXIT_IMM = 8'hc2;
    localparam logic [7:0] OP_FAR_EXIT = 8'hcb;
    localparam logic [7:0] OP_FAR_EXIT_IMM = 8'hca;

    // Modrm middle field selectors and the register mod value
    localparam logic [2:0] SUB_TEST = 3'h0;
    localparam logic [2:0] SUB_NOT = 3'h2;
    localparam logic [2:0] SUB_CALL = 3'h2;
    localparam logic [2:0] SUB_BRANCH = 3'h4;
    localparam logic [1:0] MOD_REG = 2'h3;

    // Cycle counts
    localparam logic [BASE_W-1:0] T_LOGIC_REG = 6'd3;
    localparam logic [BASE_W-1:0] T_LOGIC_MEM = 6'd10;
    localparam logic [BASE_W-1:0] T_ACC_BYTE = 6'd3;
    localparam logic [BASE_W-1:0] T_ACC_WORD = 6'd4;
    localparam logic [BASE_W-1:0] T_TEST_IMM_REG = 6'd4;
    localparam logic [BASE_W-1:0] T_TEST_IMM_MEM = 6'd10;
    localparam logic [BASE_W-1:0] T_NOT = 6'd3;
    localparam logic [BASE_W-1:0] T_ASCII_MUL_ADJ = 6'd19;
    localparam logic [BASE_W-1:0] T_ASCII_DIV_ADJ = 6'd15;
    localparam logic [BASE_W-1:0] T_BYTE_EXTEND = 6'd2;
    localparam logic [BASE_W-1:0] T_WORD_EXTEND = 6'd4;
    localparam logic [BASE_W-1:0] T_LOAD = 6'd12;
    localparam logic [BASE_W-1:0] T_STORE = 6'd10;
    localparam logic [BASE_W-1:0] T_COPY = 6'd14;
    localparam logic [BASE_W-1:0] T_CMP = 6'd22;
    localparam logic [BASE_W-1:0] T_SCAN = 6'd15;
    localparam logic [BASE_W-1:0] T_REP_COPY = 6'd8;
    localparam logic [PER_W-1:0] T_REP_COPY_N = 5'd8;
    localparam logic [BASE_W-1:0] T_REP_CMP = 6'd5;
    localparam logic [PER_W-1:0] T_REP_CMP_N = 5'd22;
    localparam logic [BASE_W-1:0] T_REP_SCAN = 6'd5;
    localparam logic [PER_W-1:0] T_REP_SCAN_N = 5'd15;
    localparam logic [BASE_W-1:0] T_REP_LOAD = 6'd6;
    localparam logic [PER_W-1:0] T_REP_LOAD_N = 5'd12;
    localparam logic [BASE_W-1:0] T_REP_STORE = 6'd6;
    localparam logic [PER_W-1:0] T_REP_STORE_N = 5'd9;
    localparam logic [BASE_W-1:0] T_CALL_IND_REG = 6'd13;
    localparam logic [BASE_W-1:0] T_CALL_IND_MEM = 6'd19;
    localparam logic [BASE_W-1:0] T_CALL_NEAR = 6'd15;
    localparam logic [BASE_W-1:0] T_CALL_FAR = 6'd23;
    localparam logic [BASE_W-1:0] T_BRANCH_IND = 6'd26;
    localparam logic [BASE_W-1:0] T_NEAR_EXIT = 6'd16;
    localparam logic [BASE_W-1:0] T_NEAR_EXIT_IMM = 6'd18;
    localparam logic [BASE_W-1:0] T_FAR_EXIT = 6'd22;
    localparam logic [BASE_W-1:0] T_FAR_EXIT_IMM = 6'd25;
    localparam logic [BASE_W-1:0] T_UNSUPPORTED = 6'd1;

    typedef enum logic [4:0] {
        CL_NONE, CL_AND, CL_TEST, CL_OR, CL_XOR, CL_NOT,
        CL_ASCII_MULTIPLY_ADJUST, CL_ASCII_DIVIDE_ADJUST,
        CL_BYTE_TO_WORD_EXTEND, CL_WORD_TO_DOUBLEWORD_EXTEND,
        CL_STRING_LOAD_ELEMENT, CL_STRING_STORE_ELEMENT, CL_STRING_COPY_ELEMENT,
        CL_STRING_COMPARE_ELEMENT, CL_STRING_SCAN_ELEMENT,
        CL_CALL_NEAR, CL_CALL_INDIRECT, CL_CALL_FAR, CL_UNCONDITIONAL_BRANCH,
        CL_SUBROUTINE_EXIT, CL_SUBROUTINE_EXIT_IMM, CL_FAR_EXIT, CL_FAR_EXIT_IMM
    } cidt_class_t;

    typedef enum logic [1:0] {DEST_NONE, DEST_RM, DEST_REG, DEST_ACC} cidt_dest_t;

    typedef enum {ST_IDLE, ST_EXEC} cidt_state_t;

    typedef struct packed {
        logic        valid;                 // Request strobe
        logic [7:0]  opcode;
        logic [7:0]  modrm;
        logic        repeat_prefix;         // Repeat prefix seen ahead of opcode
        logic [15:0] loop_count_register;   // Iteration count for repeated strings
        logic [15:0] operand_rm;            // Register or memory operand
        logic [15:0] operand_src;           // Register, immediate or accumulator_word
    } cidt_req_t;

    typedef struct packed {
        logic zero;
        logic sign;
        logic parity;
        logic carry;
        logic overflow;
    } cidt_flags_t;

    typedef struct packed {
        cidt_class_t  cls;
        cidt_dest_t   dest;
        logic         write_result;
        logic         update_flags;
        logic         unsupported;
        logic [15:0]  result;
        cidt_flags_t  flags;
        logic [CYC_W-1:0] cycles;           // Total cycles charged
    } cidt_resp_t;

endpackage

/* File: cidt_core.sv */
// Decode and execution timing engine for the logic, string and control transfer group.
// Assumes requests come from the fetch logic on the core clock and are held until accepted.
`timescale 1ns/10ps
`default_nettype none

module cidt_core
    import cidt_pkg::*;
(
    input  wire logic  clock,    // Core clock, 125 MHz
    input  wire logic  arst_n,   // Asynchronous reset, active low
    input  wire cidt_req_t req,  // Instruction request
    output logic       busy,     // Instruction in execution
    output logic       done,     // One-cycle pulse on last execution cycle
    output var cidt_resp_t resp  // Decode and result, valid with done
);

    typedef struct packed {
        logic [BASE_W-1:0] base;
        logic [PER_W-1:0]  per;
        cidt_class_t       cls;
        cidt_dest_t        dest;
        logic              writes;
        logic              flags;
        logic              known;
    } cidt_dec_t;

    typedef struct packed {
        cidt_state_t      st;
        logic [CYC_W-1:0] remain;
        logic             busy;
        logic             done;
        cidt_resp_t       resp;
    } cidt_regs_t;

    // Pick the register or memory figure from the mod field
    function automatic logic [BASE_W-1:0] rm_time(input logic [7:0] modrm,
                                                   input logic [BASE_W-1:0] t_reg,
                                                   input logic [BASE_W-1:0] t_mem);
        rm_time = (modrm[7:6] == MOD_REG) ? t_reg : t_mem;
    endfunction

    // Byte-wide operations ignore the upper lane
    function automatic logic [15:0] lane(input logic [15:0] v, input logic word);
        lane = word ? v : {8'h00, v[7:0]};
    endfunction

    // Full decode of one opcode and modrm pair
    function automatic cidt_dec_t decode(input cidt_req_t r);
        cidt_dec_t d;
        logic [7:0] op;
        logic [2:0] sub;
        d = '{base: T_UNSUPPORTED, per: '0, cls: CL_NONE, dest: DEST_NONE,
              writes: 1'b0, flags: 1'b0, known: 1'b1};
        op = r.opcode;
        sub = r.modrm[5:3];
        if ({op[7:2], 2'b00} == OP_AND_RM || {op[7:2], 2'b00} == OP_OR_RM
            || {op[7:2], 2'b00} == OP_XOR_RM) begin
            d.cls = (op[5]) ? ((op[4]) ? CL_XOR : CL_AND) : CL_OR;
            d.base = rm_time(r.modrm, T_LOGIC_REG, T_LOGIC_MEM);
            d.dest = op[1] ? DEST_REG : DEST_RM;
            d.writes = 1'b1;
            d.flags = 1'b1;
        end else if ({op[7:1], 1'b0} == OP_AND_ACC || {op[7:1], 1'b0} == OP_OR_ACC
                     || {op[7:1], 1'b0} == OP_XOR_ACC) begin
            d.cls = (op[5]) ? ((op[4]) ? CL_XOR : CL_AND) : CL_OR;
            d.base = op[0] ? T_ACC_WORD : T_ACC_BYTE;
            d.dest = DEST_ACC;
            d.writes = 1'b1;
            d.flags = 1'b1;
        end else if ({op[7:1], 1'b0} == OP_TEST_RM) begin
            d.cls = CL_TEST;
            d.base = rm_time(r.modrm, T_LOGIC_REG, T_LOGIC_MEM);
            d.flags = 1'b1;
        end else if ({op[7:1], 1'b0} == OP_TEST_ACC) begin
            d.cls = CL_TEST;
            d.base = op[0] ? T_ACC_WORD : T_ACC_BYTE;
            d.flags = 1'b1;
        end else if ({op[7:1], 1'b0} == OP_UNARY && sub == SUB_TEST) begin
            d.cls = CL_TEST;
            d.base = rm_time(r.modrm, T_TEST_IMM_REG, T_TEST_IMM_MEM);
            d.flags = 1'b1;
        end else if ({op[7:1], 1'b0} == OP_UNARY && sub == SUB_NOT) begin
            d.cls = CL_NOT;
            d.base = T_NOT;
            d.dest = DEST_RM;
            d.writes = 1'b1;
        end else if (op == OP_ASCII_MUL_ADJ) begin
            d.cls = CL_ASCII_MULTIPLY_ADJUST;
            d.base = T_ASCII_MUL_ADJ;
        end else if (op == OP_ASCII_DIV_ADJ) begin
            d.cls = CL_ASCII_DIVIDE_ADJUST;
            d.base = T_ASCII_DIV_ADJ;
        end else if (op == OP_BYTE_EXTEND) begin
            d.cls = CL_BYTE_TO_WORD_EXTEND;
            d.base = T_BYTE_EXTEND;
        end else if (op == OP_WORD_EXTEND) begin
            d.cls = CL_WORD_TO_DOUBLEWORD_EXTEND;
            d.base = T_WORD_EXTEND;
        end else if ({op[7:1], 1'b0} == OP_LOAD) begin
            d.cls = CL_STRING_LOAD_ELEMENT;
            d.base = r.repeat_prefix ? T_REP_LOAD : T_LOAD;
            d.per = r.repeat_prefix ? T_REP_LOAD_N : '0;
        end else if ({op[7:1], 1'b0} == OP_STORE) begin
            d.cls = CL_STRING_STORE_ELEMENT;
            d.base = r.repeat_prefix ? T_REP_STORE : T_STORE;
            d.per = r.repeat_prefix ? T_REP_STORE_N : '0;
        end else if ({op[7:1], 1'b0} == OP_COPY) begin
            d.cls = CL_STRING_COPY_ELEMENT;
            d.base = r.repeat_prefix ? T_REP_COPY : T_COPY;
            d.per = r.repeat_prefix ? T_REP_COPY_N : '0;
        end else if ({op[7:1], 1'b0} == OP_CMP) begin
            d.cls = CL_STRING_COMPARE_ELEMENT;
            d.base = r.repeat_prefix ? T_REP_CMP : T_CMP;
            d.per = r.repeat_prefix ? T_REP_CMP_N : '0;
        end else if ({op[7:1], 1'b0} == OP_SCAN) begin
            d.cls = CL_STRING_SCAN_ELEMENT;
            d.base = r.repeat_prefix ? T_REP_SCAN : T_SCAN;
            d.per = r.repeat_prefix ? T_REP_SCAN_N : '0;
        end else if (op == OP_CALL_NEAR) begin
            d.cls = CL_CALL_NEAR;
            d.base = T_CALL_NEAR;
        end else if (op == OP_CALL_FAR) begin
            d.cls = CL_CALL_FAR;
            d.base = T_CALL_FAR;
        end else if (op == OP_GROUP && sub == SUB_CALL) begin
            d.cls = CL_CALL_INDIRECT;
            d.base = rm_time(r.modrm, T_CALL_IND_REG, T_CALL_IND_MEM);
        end else if (op == OP_GROUP && sub == SUB_BRANCH) begin
            d.cls = CL_UNCONDITIONAL_BRANCH;
            d.base = T_BRANCH_IND;
        end else if (op == OP_NEAR_EXIT) begin
            d.cls = CL_SUBROUTINE_EXIT;
            d.base = T_NEAR_EXIT;
        end else if (op == OP_NEAR_EXIT_IMM) begin
            d.cls = CL_SUBROUTINE_EXIT_IMM;
            d.base = T_NEAR_EXIT_IMM;
        end else if (op == OP_FAR_EXIT) begin
            d.cls = CL_FAR_EXIT;
            d.base = T_FAR_EXIT;
        end else if (op == OP_FAR_EXIT_IMM) begin
            d.cls = CL_FAR_EXIT_IMM;
            d.base = T_FAR_EXIT_IMM;
        end else begin
            d.known = 1'b0;
        end
        return d;
    endfunction

    logic       rst_meta_r;
    logic       rst_sync_n_r;
    cidt_regs_t state_r;
    cidt_regs_t state_nxt;

    // Reset release is synchronised so the state register leaves reset on a clock edge; arst_n clears both synchroniser flops; they release on clock edges
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n_r <= rst_meta_r;
        end
    end

    // Accept, decode, compute and count down the charged cycles
    always_comb begin
        cidt_dec_t        d;
        logic [15:0]      a;
        logic [15:0]      b;
        logic [15:0]      res;
        logic [CYC_W-1:0] total;
        logic             word;
        d = decode(req);
        word = req.opcode[0];
        a = lane(req.operand_rm, word);
        b = lane(req.operand_src, word);
        total = '0;
        res = '0;
        state_nxt = state_r;
        state_nxt.done = 1'b0;
        case (state_r.st)
            ST_IDLE: begin
                if (req.valid) begin
                    // Count register of zero gives the base time only
                    total = CYC_W'(d.base) + CYC_W'(d.per) * CYC_W'(req.loop_count_register);
                    case (d.cls)
                        CL_OR:   res = a | b;
                        CL_XOR:  res = a ^ b;
                        CL_NOT:  res = lane(~a, word);
                        default: res = a & b;
                    endcase
                    state_nxt.resp.cls = d.cls;
                    state_nxt.resp.dest = d.dest;
                    state_nxt.resp.write_result = d.writes;
                    state_nxt.resp.update_flags = d.flags;
                    state_nxt.resp.unsupported = ~d.known;
                    state_nxt.resp.result = res;
                    state_nxt.resp.cycles = total;
                    if (d.flags) begin
                        state_nxt.resp.flags.zero = (res == 16'h0000);
                        state_nxt.resp.flags.sign = word ? res[15] : res[7];
                        state_nxt.resp.flags.parity = ~^res[7:0];
                        state_nxt.resp.flags.carry = 1'b0;             // Logic ops clear carry
                        state_nxt.resp.flags.overflow = 1'b0;
                    end
                    state_nxt.remain = total - CYC_W'(1);
                    state_nxt.busy = 1'b1;
                    state_nxt.done = (total == CYC_W'(1));
                    state_nxt.st = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (state_r.remain == '0) begin
                    state_nxt.busy = 1'b0;
                    state_nxt.st = ST_IDLE;
                end else begin
                    state_nxt.remain = state_r.remain - CYC_W'(1);
                    state_nxt.done = (state_r.remain == CYC_W'(1));
                end
            end
            default: begin
                state_nxt.st = ST_IDLE;
                state_nxt.busy = 1'b0;
            end
        endcase
    end

    // Single state register; reset only takes constants
    always_ff @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            state_r <= '{st: ST_IDLE, remain: '0, busy: 1'b0, done: 1'b0, resp: '0};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign busy = state_r.busy;
    assign done = state_r.done;
    assign resp = state_r.resp;

endmodule

`default_nettype wire

/* File: cidt_core_asserts.sv */
// Concurrent checks on the decode and execution timing block.
// Assumes binding to cidt_core; sees only its ports, single core clock.
`timescale 1ns/10ps
`default_nettype none
module cidt_core_asserts
    import cidt_pkg::*;
(
    input wire logic       clock,   // Core clock
    input wire logic       arst_n,  // Reset, active low
    input wire cidt_req_t  req,     // Request as driven
    input wire logic       busy,    // Execution in progress
    input wire logic       done,    // Last execution cycle
    input wire cidt_resp_t resp     // Decode result
);
    logic [1:0]       age_r;  // Edges since reset release, saturating
    logic [CYC_W-1:0] run_r;  // Busy cycles before the current one
    logic             take;   // Request accepted at this edge

    // Early requests fall inside the internal reset, so only trust edges from the fourth on
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            age_r <= 2'h0;
            run_r <= '0;
        end else begin
            age_r <= (age_r == 2'h3) ? age_r : age_r + 2'h1;
            run_r <= busy ? run_r + CYC_W'(1) : '0;
        end
    end
    assign take = req.valid && !busy && (age_r == 2'h3);

    default clocking dc @(posedge clock); endclocking
    default disable iff (!arst_n);

    chk_done_in_busy: assert property (done |-> busy)
        else $error("done outside busy");
    chk_busy_length: assert property (done |-> run_r + 1 == resp.cycles)
        else $error("busy length differs from charged cycles");
    chk_done_ends: assert property (done |=> !busy)
        else $error("busy outlives done");
    chk_near_exit: assert property (take && req.opcode inside {8'hc3, 8'hc2} |=>
        resp.cycles == ($past(req.opcode) == 8'hc3 ? 16 : 18)) else $error("near exit time");
    chk_far_exit: assert property (take && req.opcode inside {8'hcb, 8'hca} |=>
        resp.cycles == ($past(req.opcode) == 8'hcb ? 22 : 25)) else $error("far exit time");
    chk_adjust_time: assert property (take && req.opcode inside {8'hd4, 8'hd5} |=>
        resp.cycles == ($past(req.opcode) == 8'hd4 ? 19 : 15)) else $error("adjust time");
    chk_extend_time: assert property (take && req.opcode inside {8'h98, 8'h99} |=>
        resp.cycles == ($past(req.opcode) == 8'h98 ? 2 : 4)) else $error("extend time");
    chk_rep_copy: assert property (take && req.repeat_prefix && req.opcode[7:1] == 7'h52 |=>
        resp.cycles == 8 + 8 * $past(req.loop_count_register)) else $error("repeated copy time");
    chk_rep_load: assert property (take && req.repeat_prefix && req.opcode[7:1] == 7'h56 |=>
        resp.cycles == 6 + 12 * $past(req.loop_count_register)) else $error("repeated load time");
    chk_branch_ind: assert property (take && req.opcode == OP_GROUP && req.modrm[5:3] == SUB_BRANCH |=>
        resp.cycles == 26) else $error("indirect branch time");
    chk_test_flags: assert property (take && req.opcode == 8'h85 |=> !resp.write_result &&
        resp.flags.zero == (($past(req.operand_rm) & $past(req.operand_src)) == 16'h0))
        else $error("test flags");

    // Main scenarios reached
    cover property (take && req.repeat_prefix);
    cover property (done && resp.cycles == 1);
    cover property (done ##2 busy);
endmodule

bind cidt_core cidt_core_asserts cidt_core_asserts_i (.clock(clock), .arst_n(arst_n), .req(req),
    .busy(busy), .done(done), .resp(resp));
`default_nettype wire

/* File: cidt_tb.sv */
// Self-checking bench for the decode and execution timing block.
// Assumes the checker binds itself; requests change only at rising edges.
`timescale 1ns/10ps
`default_nettype none
module testbench import cidt_pkg::*;;
    logic        clock;
    logic        arst_n;
    cidt_req_t   req;
    logic        busy;
    logic        done;
    cidt_resp_t  resp;
    int          errors;
    int          comparisons;
    logic [31:0] seed;
    logic [7:0]  ops [40] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h08, 8'h0a, 8'h0d, 8'h30,
        8'h33, 8'h34, 8'h84, 8'h85, 8'ha8, 8'ha9, 8'hf6, 8'hf7, 8'hd4, 8'hd5, 8'h98, 8'h99, 8'ha4, 8'ha5,
        8'ha6, 8'ha7, 8'haa, 8'hab, 8'hac, 8'had, 8'hae, 8'haf, 8'he8, 8'h9a, 8'hff, 8'hc3, 8'hc2, 8'hcb,
        8'hca, 8'h90};

    cidt_core cidt_core_i (.clock(clock), .arst_n(arst_n), .req(req), .busy(busy), .done(done), .resp(resp));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Charged cycles per instruction; 0x90 lies outside the block and costs one
    function automatic logic [31:0] exp_cyc(input cidt_req_t r);
        logic mem;
        int   n;
        mem = (r.modrm[7:6] != 2'h3);
        n = r.loop_count_register;
        casez (r.opcode)
            8'b0010_00??, 8'b0000_10??, 8'b0011_00??, 8'h84, 8'h85: return mem ? 10 : 3;
            8'h24, 8'h0c, 8'h34, 8'ha8: return 3;
            8'h25, 8'h0d, 8'h35, 8'ha9: return 4;
            8'hf6, 8'hf7: return (r.modrm[5:3] == 3'h0) ? (mem ? 10 : 4) : 3;
            8'hd4: return 19;
            8'hd5: return 15;
            8'h98: return 2;
            8'h99: return 4;
            8'hac, 8'had: return r.repeat_prefix ? 6 + 12 * n : 12;
            8'haa, 8'hab: return r.repeat_prefix ? 6 + 9 * n : 10;
            8'ha4, 8'ha5: return r.repeat_prefix ? 8 + 8 * n : 14;
            8'ha6, 8'ha7: return r.repeat_prefix ? 5 + 22 * n : 22;
            8'hae, 8'haf: return r.repeat_prefix ? 5 + 15 * n : 15;
            8'he8: return 15;
            8'h9a: return 23;
            8'hff: return (r.modrm[5:3] == SUB_CALL) ? (mem ? 19 : 13) : 26;
            8'hc3: return 16;
            8'hc2: return 18;
            8'hcb: return 22;
            8'hca: return 25;
            default: return 1;
        endcase
    endfunction

    // Build a request; group opcodes get only the middle fields this block decodes
    function automatic cidt_req_t mk(input logic [7:0] op, input logic [7:0] m, input logic rp,
                                     input logic [15:0] n, input logic [31:0] s);
        cidt_req_t r;
        r = '0;
        r.opcode = op;
        r.modrm = m;
        if (op[7:1] == 7'h7b) r.modrm[5:3] = m[3] ? SUB_NOT : SUB_TEST;
        if (op == OP_GROUP) r.modrm[5:3] = m[3] ? SUB_BRANCH : SUB_CALL;
        if (op[7:1] == 7'h6a) r.modrm = 8'h0a;
        r.repeat_prefix = rp;
        r.loop_count_register = n;
        r.operand_rm = s[15:0];
        r.operand_src = s[20] ? ~s[15:0] : s[31:16];
        return r;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            errors++;
            $display("[ERR] %0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    // Issue one instruction at the current edge, follow it to completion, return on the edge busy falls
    task automatic run_one(input cidt_req_t r);
        int          n;
        logic [31:0] e;
        logic [15:0] a;
        e = exp_cyc(r);
        a = r.operand_rm & r.operand_src & (r.opcode[0] ? 16'hffff : 16'h00ff);
        r.valid = 1'b1;
        req <= r;
        #1;
        check(busy, 1'b0);
        @(posedge clock);
        #1;
        check(busy, 1'b1);
        n = 1;
        while (done !== 1'b1 && n < 2000) begin
            @(posedge clock);
            // A stray opcode while busy must be ignored, valid stays high
            if (n == 1) req.opcode <= seed[7:0];
            #1;
            n++;
        end
        check(n, e);
        check(resp.cycles, e);
        if (r.opcode[7:2] == 6'h08 || r.opcode[7:1] == 7'h42 || (r.opcode[7:1] == 7'h7b && r.modrm[5:3] == 3'h0)) begin
            check(resp.flags.zero, a == 16'h0);
            check(resp.write_result, r.opcode[7:2] == 6'h08);
        end
        if (r.opcode[7:2] == 6'h08) begin
            check(resp.result, a);
            check(resp.dest, r.opcode[1] ? DEST_REG : DEST_RM);
        end
        if (r.opcode[7:1] == 7'h7b) check(resp.cls, r.modrm[5:3] == 3'h0 ? CL_TEST : CL_NOT);
        @(posedge clock);
    endtask

    task automatic end_of_test();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Hang guard: 50000 cycles, about nine times what the random mix needs on average
    initial begin
        #400000;
        errors++;
        end_of_test();
    end

    // Register pass with zero counts, memory pass, then random back-to-back traffic
    initial begin
        errors = 0;
        comparisons = 0;
        seed = 32'h063c;
        arst_n = 1'b0;
        req = '0;
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        foreach (ops[i]) run_one(mk(ops[i], 8'hc0, 1'b1, 16'h0, 32'h00ff_00ff));
        foreach (ops[i]) run_one(mk(ops[i], 8'h06, 1'b0, 16'h1, 32'h5a5a_a5a5));
        repeat (300) begin
            seed = lfsr(seed);
            run_one(mk(ops[seed[31:26] % 40], seed[7:0], seed[8], {12'h0, seed[12:9]}, seed));
        end
        req <= '0;
        repeat (2) @(posedge clock);
        end_of_test();
    end
endmodule
`default_nettype wire
